// *** pkg/pmw_defs.svh ***
/*
  Constants of the program memory window and self-write unit: offsets,
  field positions, reset values and timing counts.
  Assumes an instruction clock of 20 MHz on both ends.
*/
// Contract
// - upper data half maps onto program page
// - window when address top bit and enable
// - page select gives upper program address bits
// - low 15 address bits map directly
// - window read adds up to two cycles
// - window returns low 16 bits only
// - software fills upper byte with nop pattern; testbench writes 00 there, not FF
// - window waits while table op runs
// - move one extra, others two extra
// - repeat edges and interrupts take two extra
// - repeat middle iterations take single cycle
// - rows hold 64 instructions, 192 bytes
// - erase eight-row page, write row or word
// - pages and rows aligned from memory start
// - 64-word holding buffer, aligned sequential loads
// - software issues 64 table writes per row; testbench issues 128, 64 low and 64 high
// - buffer table write takes two cycles
// - one programming cycle commits one row
// - core stalls while flash operation runs
// - start bit begins op, clears itself
// - row write lasts 168517 oscillator cycles
// - software writes 55 then AA key
// - flash control selects operation and start
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// ----------------------------------------------------------------
// register fields
// ----------------------------------------------------------------
`define PMW_WIN_EN_BIT   2
`define PMW_START_BIT    15
`define PMW_EA_TOP_BIT   15
`define PMW_KEY_FIRST    16'h0055
`define PMW_KEY_SECOND   16'h00AA
`define PMW_ERASED_WORD  24'hFFFFFF
`define PMW_NOP_BYTE     8'hFF

// ----------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------
`define PMW_MEM_WORDS    2048
`define PMW_ROW_WORDS    64
`define PMW_PAGE_ROWS    8
`define PMW_TBL_CYCLES   20'h00002
`define PMW_XTRA_MOVE    2'h1
`define PMW_XTRA_OTHER   2'h2
`define PMW_XTRA_RPT     2'h2
`define PMW_XTRA_MID     2'h0
`define PMW_ROW_FRC_CYC  64'd168517
`define PMW_FRC_HZ       64'd7370000
`define PMW_CLK_HZ       64'd20000000
`define PMW_ROW_CYCLES   ((`PMW_ROW_FRC_CYC * `PMW_CLK_HZ + `PMW_FRC_HZ - 64'd1) / `PMW_FRC_HZ)

// ----------------------------------------------------------------
// core-side apb register offsets
// ----------------------------------------------------------------
`define PMW_APB_CMD      12'h000
`define PMW_APB_ADDR     12'h004
`define PMW_APB_WDATA    12'h008
`define PMW_APB_STATUS   12'h00C
`define PMW_APB_RDATA    12'h010

`endif

// *** pkg/pmw_pkg.sv ***
/*
  Types shared by the window unit and the core end.
  Assumes pmw_defs.svh for all numeric constants.
*/
package pmw_pkg;
  typedef enum logic [1:0] {
    PMW_SFR_CORE = 2'b00, PMW_SFR_PAGE = 2'b01,
    PMW_SFR_FCTL = 2'b10, PMW_SFR_KEY  = 2'b11
  } pmw_sfr_t;
  typedef enum logic [1:0] {
    PMW_FOP_NONE = 2'b00, PMW_FOP_WORD = 2'b01,
    PMW_FOP_ROW  = 2'b10, PMW_FOP_ERASE = 2'b11
  } pmw_fop_t;
  typedef enum logic [1:0] {
    PMW_KEY_IDLE = 2'b00, PMW_KEY_HALF = 2'b01, PMW_KEY_ARMED = 2'b10
  } pmw_key_t;
  typedef enum logic [1:0] {
    PMW_DS_IDLE = 2'b00, PMW_DS_WAIT = 2'b01, PMW_DS_FLASH = 2'b10
  } pmw_dst_t;
  typedef enum logic [2:0] {
    PMW_CMD_DREAD = 3'b000, PMW_CMD_SFRWR = 3'b001, PMW_CMD_TWL = 3'b010,
    PMW_CMD_TWH   = 3'b011, PMW_CMD_TRL   = 3'b100, PMW_CMD_TRH = 3'b101,
    PMW_CMD_SFRRD = 3'b110
  } pmw_cmd_t;
  typedef enum logic [1:0] {
    PMW_CS_IDLE = 2'b00, PMW_CS_ISSUE = 2'b01, PMW_CS_SREAD = 2'b10
  } pmw_cst_t;
endpackage

// *** pkg/pmw_if.sv ***
/*
  Link between the processor core end and the program memory unit.
  Assumes both ends share one clock; no crossing inside.
*/
`timescale 1ns/100ps
interface pmw_if;
  // data access
  logic        data_req;
  logic [15:0] data_addr;
  logic        is_move;
  logic        in_repeat;
  logic        rpt_edge;
  logic        data_ack;
  logic        data_win;
  logic [15:0] data_rdata;
  // table access
  logic        tbl_req;
  logic        tbl_wr;
  logic        tbl_hi;
  logic [23:0] tbl_addr;
  logic [15:0] tbl_wdata;
  // special function registers
  logic        sfr_wr;
  logic [1:0]  sfr_sel;
  logic [15:0] sfr_wdata;
  logic [15:0] sfr_rdata;
  logic        stall;

  modport device (
    input  data_req, data_addr, is_move, in_repeat, rpt_edge,
    input  tbl_req, tbl_wr, tbl_hi, tbl_addr, tbl_wdata,
    input  sfr_wr, sfr_sel, sfr_wdata,
    output data_ack, data_win, data_rdata, sfr_rdata, stall
  );
  modport core (
    output data_req, data_addr, is_move, in_repeat, rpt_edge,
    output tbl_req, tbl_wr, tbl_hi, tbl_addr, tbl_wdata,
    output sfr_wr, sfr_sel, sfr_wdata,
    input  data_ack, data_win, data_rdata, sfr_rdata, stall
  );
endinterface // pmw_if

// *** design/pmw_device.sv ***
/*
  Program memory unit: data-space window onto program flash, holding
  buffer, unlock key and timed self-write of word or row, and page erase.
  Assumes one outstanding core request at a time, held until acked.
*/
`timescale 1ns/100ps
`include "pmw_defs.svh"
module pmw_device
  import pmw_pkg::*;
#(
  parameter int OP_CYCLES = int'(`PMW_ROW_CYCLES)
) (
  // clock and reset
  input  wire logic MCLK_IN,
  input  wire logic RESET_IN,
  // core link
  pmw_if.device     bus,
  // status
  output logic      FLASH_BUSY_OUT,
  output logic      KEY_ARMED_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte address to word index; pc steps by 2 per word
  function automatic logic [10:0] word_idx(input logic [23:0] a);
    return a[11:1];
  endfunction

  // extra window cycles from instruction class
  function automatic logic [1:0] xtra(input logic mv, input logic rp, input logic ed);
    if (rp && ed)
      return `PMW_XTRA_RPT;
    else if (rp)
      return `PMW_XTRA_MID;
    else if (mv)
      return `PMW_XTRA_MOVE;
    else
      return `PMW_XTRA_OTHER;
  endfunction

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [23:0] mem_q  [0:`PMW_MEM_WORDS-1];
  logic [23:0] hbuf_q [0:`PMW_ROW_WORDS-1];
  pmw_dst_t    st_q;
  pmw_key_t    key_q;
  pmw_fop_t    fop_q;
  logic        win_en_q;
  logic [7:0]  page_q;
  logic        start_q;
  logic [19:0] cnt_q;
  logic        p_tbl_q;
  logic        p_wr_q;
  logic        p_hi_q;
  logic [10:0] idx_q;
  logic [15:0] wdata_q;
  logic [10:0] last_q;
  logic        ack_q;
  logic        win_q;
  logic [15:0] rdata_q;
  logic [15:0] sfr_rdata_q;

  logic        take_tbl;
  logic        take_data;
  logic        win_hit;
  logic [1:0]  dx;
  logic [10:0] widx;
  logic        fctl_wr;
  logic        start_ok;
  logic        wait_end;
  logic        flash_done;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // ack_q blocks a second take of a request still held for one edge
  assign take_tbl   = (st_q == PMW_DS_IDLE) && !ack_q && bus.tbl_req;
  assign take_data  = (st_q == PMW_DS_IDLE) && !ack_q && bus.data_req && !bus.tbl_req;
  assign win_hit    = bus.data_addr[`PMW_EA_TOP_BIT] && win_en_q;
  assign widx       = word_idx({1'b0, page_q, bus.data_addr[14:0]});
  assign dx         = xtra(bus.is_move, bus.in_repeat, bus.rpt_edge);
  assign fctl_wr    = bus.sfr_wr && (pmw_sfr_t'(bus.sfr_sel) == PMW_SFR_FCTL);
  assign start_ok   = fctl_wr && bus.sfr_wdata[`PMW_START_BIT] && (key_q == PMW_KEY_ARMED)
                      && (bus.sfr_wdata[1:0] != PMW_FOP_NONE) && (st_q == PMW_DS_IDLE);
  assign wait_end   = (st_q == PMW_DS_WAIT) && (cnt_q == 20'h00001);
  assign flash_done = (st_q == PMW_DS_FLASH) && (cnt_q == 20'h00000);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one counter serves access waits and the flash timer
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_q  <= PMW_DS_IDLE;
      cnt_q <= 20'h00000;
    end else begin
      case (st_q)
        PMW_DS_IDLE: begin
          if (start_ok) begin
            st_q  <= PMW_DS_FLASH;
            cnt_q <= 20'(OP_CYCLES - 1);
          end else if (take_tbl) begin
            st_q  <= PMW_DS_WAIT;
            cnt_q <= `PMW_TBL_CYCLES - 20'h00001;
          end else if (take_data && win_hit && (dx != 2'h0)) begin
            st_q  <= PMW_DS_WAIT;
            cnt_q <= {18'h00000, dx};
          end
        end
        PMW_DS_WAIT: begin
          cnt_q <= cnt_q - 20'h00001;
          if (wait_end) begin
            st_q <= PMW_DS_IDLE;
          end
        end
        PMW_DS_FLASH: begin
          cnt_q <= cnt_q - 20'h00001;
          if (flash_done) begin
            st_q <= PMW_DS_IDLE;
          end
        end
        default: begin
          st_q <= PMW_DS_IDLE;
        end
      endcase
    end
  end

  // latch the pending access
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      p_tbl_q <= 1'b0;
      p_wr_q  <= 1'b0;
      p_hi_q  <= 1'b0;
      idx_q   <= 11'h000;
      wdata_q <= 16'h0000;
    end else if (take_tbl) begin
      p_tbl_q <= 1'b1;
      p_wr_q  <= bus.tbl_wr;
      p_hi_q  <= bus.tbl_hi;
      idx_q   <= word_idx(bus.tbl_addr);
      wdata_q <= bus.tbl_wdata;
    end else if (take_data) begin
      p_tbl_q <= 1'b0;
      p_wr_q  <= 1'b0;
      p_hi_q  <= 1'b0;
      idx_q   <= widx;
    end
  end

  // answer: ack pulse with registered data
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ack_q   <= 1'b0;
      win_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (take_data && (!win_hit || (dx == 2'h0))) begin
      ack_q   <= 1'b1;
      win_q   <= win_hit;
      rdata_q <= win_hit ? mem_q[widx][15:0] : 16'h0000;
    end else if (wait_end) begin
      ack_q   <= 1'b1;
      win_q   <= !p_tbl_q;
      if (p_wr_q)
        rdata_q <= 16'h0000;
      else if (p_tbl_q && p_hi_q)
        rdata_q <= {8'h00, mem_q[idx_q][23:16]};
      else
        rdata_q <= mem_q[idx_q][15:0];
    end else begin
      ack_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers and unlock key
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      win_en_q <= 1'b0;
      page_q   <= 8'h00;
      fop_q    <= PMW_FOP_NONE;
      start_q  <= 1'b0;
    end else begin
      if (bus.sfr_wr && (pmw_sfr_t'(bus.sfr_sel) == PMW_SFR_CORE))
        win_en_q <= bus.sfr_wdata[`PMW_WIN_EN_BIT];
      if (bus.sfr_wr && (pmw_sfr_t'(bus.sfr_sel) == PMW_SFR_PAGE))
        page_q <= bus.sfr_wdata[7:0];
      if (fctl_wr && !start_q)
        fop_q <= pmw_fop_t'(bus.sfr_wdata[1:0]);
      if (flash_done)
        start_q <= 1'b0;
      else if (start_ok)
        start_q <= 1'b1;
    end
  end

  // any other register write between key and start disarms
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      key_q <= PMW_KEY_IDLE;
    end else if (bus.sfr_wr) begin
      if (pmw_sfr_t'(bus.sfr_sel) != PMW_SFR_KEY)
        key_q <= PMW_KEY_IDLE;
      else if (bus.sfr_wdata == `PMW_KEY_FIRST)
        key_q <= PMW_KEY_HALF;
      else if ((bus.sfr_wdata == `PMW_KEY_SECOND) && (key_q == PMW_KEY_HALF))
        key_q <= PMW_KEY_ARMED;
      else
        key_q <= PMW_KEY_IDLE;
    end
  end

  // register readback; key reads as zero since it is write-only
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sfr_rdata_q <= 16'h0000;
    end else begin
      case (pmw_sfr_t'(bus.sfr_sel))
        PMW_SFR_CORE: sfr_rdata_q <= {13'h0000, win_en_q, 2'b00};
        PMW_SFR_PAGE: sfr_rdata_q <= {8'h00, page_q};
        PMW_SFR_FCTL: sfr_rdata_q <= {start_q, 13'h0000, fop_q};
        default:      sfr_rdata_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // holding buffer
  // ----------------------------------------------------------------
  // slot follows the low address bits, so loads must stay in one row
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < `PMW_ROW_WORDS; i++)
        hbuf_q[i] <= `PMW_ERASED_WORD;
      last_q <= 11'h000;
    end else if (wait_end && p_tbl_q && p_wr_q) begin
      if (p_hi_q)
        hbuf_q[idx_q[5:0]][23:16] <= wdata_q[7:0];
      else
        hbuf_q[idx_q[5:0]][15:0] <= wdata_q;
      last_q <= idx_q;
    end
  end

  // ----------------------------------------------------------------
  // flash array
  // ----------------------------------------------------------------
  // commit at timer end: row of last load, its page, or one word
  for (genvar g = 0; g < `PMW_MEM_WORDS; g++) begin : g_word
    localparam logic [10:0] GI = 11'(g);
    always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        mem_q[g] <= `PMW_ERASED_WORD;
      end else if (flash_done) begin
        if ((fop_q == PMW_FOP_ERASE) && (GI[10:9] == last_q[10:9]))
          mem_q[g] <= `PMW_ERASED_WORD;
        else if ((fop_q == PMW_FOP_ROW) && (GI[10:6] == last_q[10:6]))
          mem_q[g] <= hbuf_q[GI[5:0]];
        else if ((fop_q == PMW_FOP_WORD) && (GI == last_q))
          mem_q[g] <= hbuf_q[GI[5:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.stall      = (st_q == PMW_DS_FLASH);
  assign bus.data_ack   = ack_q;
  assign bus.data_win   = win_q;
  assign bus.data_rdata = rdata_q;
  assign bus.sfr_rdata  = sfr_rdata_q;
  assign FLASH_BUSY_OUT = (st_q == PMW_DS_FLASH);
  assign KEY_ARMED_OUT  = (key_q == PMW_KEY_ARMED);

endmodule // pmw_device

// *** design/pmw_core.sv ***
/*
  Core end: takes commands from software over APB and issues data,
  table and register accesses on the link, one at a time.
  Assumes an APB master on the same clock; pready is always high.
*/
`timescale 1ns/100ps
`include "pmw_defs.svh"
module pmw_core
  import pmw_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // link
  pmw_if.core              bus
);

  pmw_cst_t    st_q;
  pmw_cmd_t    cmd_q;
  logic [2:0]  cls_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] res_q;
  logic        win_q;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic        is_acc;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign acc    = PSEL_IN && PENABLE_IN;
  assign wr     = acc && PWRITE_IN;
  assign mapped = (PADDR_IN == `PMW_APB_CMD) || (PADDR_IN == `PMW_APB_ADDR) ||
                  (PADDR_IN == `PMW_APB_WDATA) || (PADDR_IN == `PMW_APB_STATUS) ||
                  (PADDR_IN == `PMW_APB_RDATA);
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = acc && !mapped;
  assign is_acc = (cmd_q != PMW_CMD_SFRWR) && (cmd_q != PMW_CMD_SFRRD);

  // read data latched in the setup phase so it stands through access;
  // status shows busy, stall and last window hit
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL_IN && !PENABLE_IN) begin
      case (PADDR_IN)
        `PMW_APB_CMD:    prdata_q <= {26'h0000000, cls_q, cmd_q};
        `PMW_APB_ADDR:   prdata_q <= {8'h00, addr_q};
        `PMW_APB_WDATA:  prdata_q <= {16'h0000, wdata_q};
        `PMW_APB_STATUS: prdata_q <= {29'h00000000, win_q, bus.stall, st_q != PMW_CS_IDLE};
        `PMW_APB_RDATA:  prdata_q <= {16'h0000, res_q};
        default:         prdata_q <= 32'h00000000;
      endcase
    end
  end
  assign PRDATA_OUT = prdata_q;

  // operand registers
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      addr_q  <= 24'h000000;
      wdata_q <= 16'h0000;
    end else if (wr && (st_q == PMW_CS_IDLE)) begin
      if (PADDR_IN == `PMW_APB_ADDR)
        addr_q <= PWDATA_IN[23:0];
      if (PADDR_IN == `PMW_APB_WDATA)
        wdata_q <= PWDATA_IN[15:0];
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // a command written while busy is dropped; software polls status
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_q  <= PMW_CS_IDLE;
      cmd_q <= PMW_CMD_DREAD;
      cls_q <= 3'h0;
      res_q <= 16'h0000;
      win_q <= 1'b0;
    end else begin
      case (st_q)
        PMW_CS_IDLE: begin
          if (wr && (PADDR_IN == `PMW_APB_CMD)) begin
            cmd_q <= pmw_cmd_t'(PWDATA_IN[2:0]);
            cls_q <= PWDATA_IN[5:3];
            st_q  <= PMW_CS_ISSUE;
          end
        end
        PMW_CS_ISSUE: begin
          if (cmd_q == PMW_CMD_SFRRD)
            st_q <= PMW_CS_SREAD;
          else if (!is_acc && !bus.stall)
            st_q <= PMW_CS_IDLE;
          else if (is_acc && bus.data_ack) begin
            res_q <= bus.data_rdata;
            win_q <= bus.data_win;
            st_q  <= PMW_CS_IDLE;
          end
        end
        PMW_CS_SREAD: begin
          res_q <= bus.sfr_rdata;
          st_q  <= PMW_CS_IDLE;
        end
        default: begin
          st_q <= PMW_CS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // requests are held until ack and withheld while flash is busy
  assign bus.data_req  = (st_q == PMW_CS_ISSUE) && (cmd_q == PMW_CMD_DREAD) && !bus.stall;
  assign bus.tbl_req   = (st_q == PMW_CS_ISSUE) && is_acc && (cmd_q != PMW_CMD_DREAD)
                         && !bus.stall;
  assign bus.tbl_wr    = (cmd_q == PMW_CMD_TWL) || (cmd_q == PMW_CMD_TWH);
  assign bus.tbl_hi    = (cmd_q == PMW_CMD_TWH) || (cmd_q == PMW_CMD_TRH);
  assign bus.tbl_addr  = addr_q;
  assign bus.tbl_wdata = wdata_q;
  assign bus.data_addr = addr_q[15:0];
  assign bus.is_move   = cls_q[0];
  assign bus.in_repeat = cls_q[1];
  assign bus.rpt_edge  = cls_q[2];
  assign bus.sfr_wr    = (st_q == PMW_CS_ISSUE) && (cmd_q == PMW_CMD_SFRWR) && !bus.stall;
  assign bus.sfr_sel   = addr_q[1:0];
  assign bus.sfr_wdata = wdata_q;

endmodule // pmw_core

// *** tb/pmw_assertions.sv ***
/*
  Checker for the link between the core end and the program memory unit.
  Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/100ps
`include "pmw_defs.svh"
module pmw_assertions #(
  parameter int OP_CYCLES = 20
) (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RESET_IN,
  // requests
  input wire logic        data_req,
  input wire logic [15:0] data_addr,
  input wire logic        is_move,
  input wire logic        in_repeat,
  input wire logic        rpt_edge,
  input wire logic        tbl_req,
  // answers
  input wire logic        data_ack,
  input wire logic        data_win,
  input wire logic        stall,
  // register writes
  input wire logic        sfr_wr,
  input wire logic [1:0]  sfr_sel,
  input wire logic [15:0] sfr_wdata
);
  // ----------------
  // helper state
  // ----------------
  logic        busy_q;
  logic        win_en_q;
  logic        key1_q;
  logic        key2_q;
  logic [15:0] cnt_q;
  wire take  = (data_req | tbl_req) & ~data_ack & ~busy_q;
  wire dtake = take & data_req & ~tbl_req;
  wire win   = data_addr[`PMW_EA_TOP_BIT] & win_en_q;
  // a start with an empty op field is no start at all
  wire start = sfr_wr & (sfr_sel == 2'h2) & sfr_wdata[`PMW_START_BIT]
             & (sfr_wdata[1:0] != 2'h0);

  // one request outstanding, taken while idle
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) busy_q <= 1'b0;
    else if (data_ack) busy_q <= 1'b0;
    else if (take) busy_q <= 1'b1;
  end
  // window enable shadow
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) win_en_q <= 1'b0;
    else if (sfr_wr && sfr_sel == 2'h0) win_en_q <= sfr_wdata[`PMW_WIN_EN_BIT];
  end
  // key history: any other register write breaks the pair
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      key1_q <= 1'b0;
      key2_q <= 1'b0;
    end else if (sfr_wr) begin
      key1_q <= sfr_sel == 2'h3 && sfr_wdata == `PMW_KEY_FIRST;
      key2_q <= sfr_sel == 2'h3 && sfr_wdata == `PMW_KEY_SECOND && key1_q;
    end
  end
  // length of the current stall
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) cnt_q <= 16'h0000;
    else cnt_q <= stall ? cnt_q + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);

  AST_WIN_MOVE: assert property (
    dtake && win && is_move && !in_repeat |=> !data_ack ##1 data_ack && data_win)
    else $error("window move latency wrong");
  AST_WIN_OTHER: assert property (
    dtake && win && !is_move && !in_repeat |=> !data_ack [*2] ##1 data_ack && data_win)
    else $error("window other latency wrong");
  AST_RPT_EDGE: assert property (
    dtake && win && in_repeat && rpt_edge |=> !data_ack [*2] ##1 data_ack && data_win)
    else $error("repeat edge latency wrong");
  AST_RPT_MID: assert property (
    dtake && win && in_repeat && !rpt_edge |=> data_ack && data_win)
    else $error("repeat middle latency wrong");
  AST_PLAIN: assert property (
    dtake && !win |=> data_ack && !data_win)
    else $error("plain data access wrong");
  AST_TBL: assert property (
    take && tbl_req |=> !data_ack ##1 data_ack)
    else $error("table access latency wrong");
  AST_START: assert property (
    start && key2_q && !stall |=> stall)
    else $error("keyed start ignored");
  AST_REFUSE: assert property (
    start && !key2_q && !stall |=> !stall)
    else $error("unkeyed start accepted");
  AST_OP_LEN: assert property (
    $fell(stall) |-> int'(cnt_q) >= OP_CYCLES && int'(cnt_q) <= OP_CYCLES + 1)
    else $error("flash operation length wrong");

  cover property (dtake && win && in_repeat);
  cover property (start && key2_q);
  cover property (take && tbl_req);
endmodule // pmw_assertions

// *** tb/testbench.sv ***
/*
  Testbench: software over APB loads and commits a row, reads it
  through the window in every mode, then erases its page.
  Assumes both ends on one 20 MHz clock.
*/
`timescale 1ns/100ps
`include "pmw_defs.svh"
module testbench
  import pmw_pkg::*;
;
  localparam int OPC = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        busy;
  logic        armed;
  logic [2:0]  modes [4] = '{3'b001, 3'b000, 3'b110, 3'b010};
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  pmw_if link ();
  pmw_device #(.OP_CYCLES(OPC)) pmw_device_i (.MCLK_IN(clk), .RESET_IN(rst), .bus(link),
    .FLASH_BUSY_OUT(busy), .KEY_ARMED_OUT(armed));
  pmw_core pmw_core_i (.MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .bus(link));
  pmw_assertions #(.OP_CYCLES(OPC)) pmw_assertions_i (.MCLK_IN(clk), .RESET_IN(rst),
    .data_req(link.data_req), .data_addr(link.data_addr), .is_move(link.is_move),
    .in_repeat(link.in_repeat), .rpt_edge(link.rpt_edge), .tbl_req(link.tbl_req),
    .data_ack(link.data_ack), .data_win(link.data_win), .stall(link.stall),
    .sfr_wr(link.sfr_wr), .sfr_sel(link.sfr_sel), .sfr_wdata(link.sfr_wdata));

  always #25 clk = ~clk;

  // -------------
  // bus tasks
  // -------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one core command; result lands in rd
  task automatic op(input logic [5:0] c, input logic [23:0] a, input logic [15:0] d);
    apb(1'b1, `PMW_APB_ADDR, {8'h00, a});
    apb(1'b1, `PMW_APB_WDATA, {16'h0000, d});
    apb(1'b1, `PMW_APB_CMD, {26'h0, c});
    do apb(1'b0, `PMW_APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
    apb(1'b0, `PMW_APB_RDATA, 32'h0);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic sfr(input logic [1:0] sel, input logic [15:0] d);
    op({3'h0, PMW_CMD_SFRWR}, {22'h0, sel}, d);
  endtask
  // bounded wait, since a missing stall must not hang the run
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, busy}, {31'h0, v});
  endtask
  task automatic start(input logic [15:0] f);
    sfr(2'h3, `PMW_KEY_FIRST);
    sfr(2'h3, `PMW_KEY_SECOND);
    chk({31'h0, armed}, 32'h1);
    sfr(2'h2, f);
  endtask
  task automatic wread(input logic [2:0] f, input int i);
    op({f, PMW_CMD_DREAD}, 24'h008000 + 24'(i * 2), 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, sized well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      conclude();
    end
  end

  // -------------
  // tests
  // -------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `PMW_APB_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 64; i++) begin
      op({3'h0, PMW_CMD_TWL}, 24'(128 + i * 2), {8'hA5, 8'(i)});
      op({3'h0, PMW_CMD_TWH}, 24'(128 + i * 2), 16'h0000);
    end
    start(16'h8002);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op({3'h0, PMW_CMD_SFRRD}, 24'h000002, 16'h0000);
    chk(rd, 32'h0002);
    $display("row write test done");
    sfr(2'h0, 16'h0004);
    sfr(2'h1, 16'h003C);
    for (int m = 0; m < 4; m++) begin
      wread(modes[m], 64 + m * 21);
      chk(rd, {16'h0, 8'hA5, 8'(m * 21)});
    end
    apb(1'b0, `PMW_APB_STATUS, 32'h0);
    chk(rd, 32'h4);
    wread(3'b001, 128);
    chk(rd, 32'hFFFF);
    op({3'h0, PMW_CMD_DREAD}, 24'h000080, 16'h0000);
    apb(1'b0, `PMW_APB_STATUS, 32'h0);
    chk(rd, 32'h0);
    op({3'h0, PMW_CMD_TRL}, 24'd130, 16'h0000);
    chk(rd, 32'hA501);
    op({3'h0, PMW_CMD_TRH}, 24'd130, 16'h0000);
    chk(rd, 32'h0);
    $display("window test done");
    sfr(2'h2, 16'h8002);
    repeat (25) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    sfr(2'h3, `PMW_KEY_FIRST);
    sfr(2'h1, 16'h003C);
    sfr(2'h3, `PMW_KEY_SECOND);
    chk({31'h0, armed}, 32'h0);
    sfr(2'h2, 16'h8003);
    repeat (25) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    start(16'h8003);
    wait_busy(1'b1);
    wait_busy(1'b0);
    wread(3'b000, 64);
    chk(rd, 32'hFFFF);
    op({3'h0, PMW_CMD_TRH}, 24'd128, 16'h0000);
    chk(rd, 32'hFF);
    $display("lock and erase test done");
    conclude();
  end
endmodule // testbench
